// ---- include/bcd_dec_if.sv ----
// Opcode byte to decoded fields carrier
`timescale 1ns/10ps
`default_nettype none
interface bcd_dec_if;
  import bcd_pkg::*;
  logic [7:0] opcode;
  bcd_dec_s   dec;
  modport dec_mp (input opcode, output dec);
  modport use_mp (output opcode, input dec);
endinterface : bcd_dec_if
`default_nettype wire

// ---- include/bcd_defs.svh ----
// Constants of the byte processor opcode decoder
`ifndef BCD_DEFS_SVH
`define BCD_DEFS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define BCD_CLK_MHZ      40.0
`define BCD_UCYC_US      1.4
`define BCD_MEM_US       0.56
`define BCD_UC_CLKS      int'(`BCD_UCYC_US * `BCD_CLK_MHZ)
`define BCD_MEM_CLKS     int'($ceil(`BCD_MEM_US * `BCD_CLK_MHZ))

// ----------------------------------------
// Microcycle costs
// ----------------------------------------
`define BCD_N_SHORT      5'd3
`define BCD_N_STAT       5'd4
`define BCD_N_XCH        5'd5
`define BCD_N_ADD_IMMEDIATE_SKIP_ZERO       5'd6
`define BCD_N_BOC        5'd7
`define BCD_N_BOC_TAKEN  5'd6
`define BCD_N_LD         5'd8
`define BCD_N_SKIP       5'd9
`define BCD_N_ST         5'd10
`define BCD_N_ISZ        5'd11
`define BCD_N_JMP        5'd10
`define BCD_N_JSR        5'd14
`define BCD_N_HALT       5'd1
`define BCD_N_IDX        5'd2
`define BCD_N_BASE       5'd1
`define BCD_N_SKIP_ADD   5'd3

// ----------------------------------------
// Condition selectors and flag numbers
// ----------------------------------------
`define BCD_CC_CARRY_OR_OVERFLOW_COND      4'h5
`define BCD_CC_USER      4'hf
`define BCD_FLAG_SEL     3'd6
`define BCD_FLAG_INTERRUPT_ENABLE_FLAG    3'd7

// ----------------------------------------
// Registers
// ----------------------------------------
`define BCD_REG_CTRL     8'h00
`define BCD_REG_STATUS   8'h04
`define BCD_REG_LAST     8'h08
`define BCD_REG_COUNT    8'h0c
`define BCD_CTRL_EN_BIT  0
`define BCD_CTRL_RST     1'b1

`endif

// ---- include/bcd_pkg.sv ----
// Types of the byte processor opcode decoder
package bcd_pkg;

  typedef enum logic [5:0] {
    OP_NOP, OP_HALT, OP_BRANCH_ON_CONDITION, OP_SET_FLAG, OP_PULSE_FLAG,
    OP_REG_REG_ADD, OP_REG_REG_XOR, OP_REG_REG_EXCHANGE, OP_REG_REG_AND,
    OP_LOAD, OP_STORE, OP_ADD, OP_SKIP_IF_NOT_EQUAL, OP_AND, OP_OR,
    OP_SKIP_IF_AND_ZERO, OP_SUBTRACT, OP_JUMP, OP_JUMP_TO_SUBROUTINE,
    OP_INCREMENT_SKIP_ZERO, OP_DECREMENT_SKIP_ZERO, OP_LOAD_IMMEDIATE,
    OP_ADD_IMMEDIATE_SKIP_ZERO, OP_EXCHANGE_WITH_STACK, OP_PUSH, OP_PULL,
    OP_NEGATE_ACCUMULATOR, OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_ROTATE_LEFT,
    OP_ROTATE_RIGHT, OP_INTERRUPT_RETURN, OP_SUB_RETURN, OP_PUSH_STATUS,
    OP_PULL_STATUS
  } bcd_op_e;

  typedef enum logic [4:0] {
    ST_IDLE       = 5'b00001,
    ST_MEM        = 5'b00010,
    ST_UCYC       = 5'b00100,
    ST_HALT_PRESS = 5'b01000,
    ST_HALT_REL   = 5'b10000
  } bcd_state_e;

  typedef struct packed {
    bcd_op_e    op;
    logic [1:0] acc_dst;
    logic [1:0] acc_src;
    logic [1:0] mode;
    logic [3:0] cond;
    logic [2:0] flag;
    logic [4:0] ucyc;
    logic [2:0] reads;
    logic       writes;
    logic       skippable;
  } bcd_dec_s;

endpackage : bcd_pkg

// ---- logic/bcd_op_decoder.sv ----
// Combinational opcode decoder with cost table
`timescale 1ns/10ps
`default_nettype none
`include "bcd_defs.svh"
module bcd_op_decoder
  import bcd_pkg::*;
(
  bcd_dec_if.dec_mp d
);

  // Indexed forms cost extra, base page adds for jumps
  function automatic logic [4:0] mem_cost(input logic [4:0] base, input logic [1:0] mode);
    mem_cost = mode[1] ? 5'(base + `BCD_N_IDX) : base;
  endfunction : mem_cost

  logic [7:0] op;
  bcd_dec_s   r;

  assign op = d.opcode;
  assign d.dec = r;

  always_comb begin
    r           = '0;
    r.op        = OP_NOP; // RULE_24
    r.ucyc      = `BCD_N_SHORT;
    r.reads     = 3'd1;
    r.acc_dst   = op[1:0];
    r.acc_src   = op[3:2];
    r.mode      = op[1:0]; // RULE_09
    r.cond      = op[3:0];
    r.flag      = op[2:0];
    case (op[7:4])
      4'h0: begin
        case (op[3:0])
          4'h0: begin r.op = OP_HALT; r.ucyc = `BCD_N_HALT; end // RULE_22
          4'h1: begin r.op = OP_INTERRUPT_RETURN; r.ucyc = `BCD_N_XCH; end // RULE_13
          4'h2: begin r.op = OP_SUB_RETURN; r.ucyc = `BCD_N_STAT; end
          4'h7: begin r.op = OP_PUSH_STATUS; r.ucyc = `BCD_N_STAT; end
          4'he: begin r.op = OP_PULL_STATUS; r.ucyc = `BCD_N_STAT; end
          default: ;
        endcase
      end
      4'h1: begin
        r.op = OP_BRANCH_ON_CONDITION; // RULE_01
        r.reads = 3'd2; // RULE_14
        r.ucyc = `BCD_N_BOC;
      end
      4'h2, 4'h3: begin
        if (op[3]) begin
          r.op = op[4] ? OP_PULSE_FLAG : OP_SET_FLAG; // RULE_03 RULE_04
        end else if (op[2] == 1'b0) begin
          r.reads = 3'd2; // RULE_11
          r.op = op[4] ? OP_ADD_IMMEDIATE_SKIP_ZERO : OP_LOAD_IMMEDIATE;
          r.ucyc = op[4] ? `BCD_N_ADD_IMMEDIATE_SKIP_ZERO : `BCD_N_XCH; // RULE_15
          r.skippable = op[4];
        end
      end
      4'h4, 4'h5, 4'h6, 4'h7: begin
        case (op[5:4]) // RULE_07
          2'd0: r.op = OP_REG_REG_ADD;
          2'd1: r.op = OP_REG_REG_XOR;
          2'd2: begin r.op = OP_REG_REG_EXCHANGE; r.ucyc = `BCD_N_XCH; end
          default: r.op = OP_REG_REG_AND;
        endcase
      end
      4'h8, 4'h9, 4'ha, 4'hb: begin
        r.acc_dst = op[3:2]; // RULE_08
        r.reads = 3'd3;
        case (op[5:4])
          2'd0: begin r.op = OP_LOAD; r.ucyc = mem_cost(`BCD_N_LD, op[1:0]); end
          2'd1: begin // RULE_16
            r.op = OP_STORE;
            r.writes = 1'b1;
            r.ucyc = mem_cost(`BCD_N_ST, op[1:0]);
          end
          2'd2: begin r.op = OP_ADD; r.ucyc = mem_cost(`BCD_N_LD, op[1:0]); end
          default: begin // RULE_17
            r.op = OP_SKIP_IF_NOT_EQUAL;
            r.skippable = 1'b1;
            r.ucyc = mem_cost(`BCD_N_SKIP, op[1:0]);
          end
        endcase
      end
      default: begin
        if (op[3]) begin // RULE_12
          r.acc_dst = op[1:0];
          case (op[5:2])
            4'h2: begin r.op = OP_EXCHANGE_WITH_STACK; r.ucyc = `BCD_N_XCH; end
            4'h3: r.op = OP_PUSH;
            4'h6: r.op = OP_PULL;
            4'h7: r.op = OP_NEGATE_ACCUMULATOR;
            4'ha: r.op = OP_SHIFT_LEFT;
            4'hb: r.op = OP_SHIFT_RIGHT;
            4'he: r.op = OP_ROTATE_LEFT;
            default: r.op = OP_ROTATE_RIGHT;
          endcase
        end else if (op[2] == 1'b0) begin // RULE_10
          r.acc_dst = 2'd0;
          r.reads = 3'd3;
          r.ucyc = mem_cost(`BCD_N_LD, op[1:0]); // RULE_15
          case (op[5:4])
            2'd0: r.op = OP_AND;
            2'd1: r.op = OP_OR;
            2'd2: begin // RULE_17
              r.op = OP_SKIP_IF_AND_ZERO;
              r.skippable = 1'b1;
              r.ucyc = mem_cost(`BCD_N_SKIP, op[1:0]);
            end
            default: r.op = OP_SUBTRACT;
          endcase
        end else begin
          r.acc_dst = 2'd0;
          r.reads = 3'd2;
          case (op[5:4]) // RULE_19
            2'd0: r.op = OP_JUMP;
            2'd1: r.op = OP_JUMP_TO_SUBROUTINE;
            2'd2: r.op = OP_INCREMENT_SKIP_ZERO;
            default: r.op = OP_DECREMENT_SKIP_ZERO;
          endcase
          if (op[5]) begin // RULE_18
            r.reads = 3'd3;
            r.writes = 1'b1;
            r.skippable = 1'b1;
            r.ucyc = mem_cost(`BCD_N_ISZ, op[1:0]);
          end else begin
            r.ucyc = op[4] ? `BCD_N_JSR : `BCD_N_JMP; // RULE_19
            if (op[1:0] == 2'd0) r.ucyc = 5'(r.ucyc + `BCD_N_BASE);
          end
        end
      end
    endcase
  end

endmodule : bcd_op_decoder
`default_nettype wire

// ---- logic/bcd_top.sv ----
// Instruction decoder and execution timer of the byte processor
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
`include "bcd_defs.svh"
// Contract
// [RULE_01] 0x10-0x1F branch, low digit is condition
// [RULE_02] Condition 15 routes user jump input
// [RULE_03] 0x28-0x2F set flag low digit minus 8
// [RULE_04] 0x38-0x3F pulse flag low digit minus 8
// [RULE_05] Flags 1-4 drive user flag outputs
// [RULE_06] Flag 6 select, flag 7 interrupt enable
// [RULE_07] 0x40-0x7F register ops, source and destination
// [RULE_08] High digit 8/9/A/B: load/store/add/skip-not-equal
// [RULE_09] Mode: base, current, third, fourth indexed
// [RULE_10] C0-F7 first accumulator memory and jump ops
// [RULE_11] 0x20-0x23 load immediate, 0x30-0x33 add-skip
// [RULE_12] C8-FF single accumulator operations
// [RULE_13] Short ops 3, status 4, exchanges 5
// [RULE_14] Branch 7 cycles, 6 when taken
// [RULE_15] Load group 8/10, add-immediate-skip 6/9
// [RULE_16] Store 10, indexed 12, one write
// [RULE_17] Skip compares 9/11, plus 3 skipping
// [RULE_18] Increment/decrement skip 11/13, plus 3 skipping
// [RULE_19] Jump 10/11, subroutine 14/15
// [RULE_20] Microcycle lasts 1.4 microseconds
// [RULE_21] Each memory access adds 0.56 microseconds
// [RULE_22] Halt waits start press then release
// [RULE_23] Condition 5 tests overflow or carry
// [RULE_24] Unassigned opcodes act as no operation
module bcd_top
  import bcd_pkg::*;
#(
  parameter int UC_CLKS  = `BCD_UC_CLKS,
  parameter int MEM_CLKS = `BCD_MEM_CLKS
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Instruction byte
  input  wire logic        instr_valid_i,
  input  wire logic [7:0]  instr_byte_i,
  output logic             instr_ready_o,
  // Processor state for conditions
  input  wire logic [7:0]  ac0_i,
  input  wire logic        carry_i,
  input  wire logic        ovf_i,
  input  wire logic        stk_full_i,
  input  wire logic        intr_i,
  input  wire logic        skip_cond_i,
  input  wire logic        flag_load_i,
  input  wire logic [7:0]  flag_load_data_i,
  // Pins
  input  wire logic        user_jump_condition_in_i,
  input  wire logic        start_sw_i,
  // Decoded fields to sequencer
  output bcd_op_e          op_class_o,
  output logic      [1:0]  acc_dst_o,
  output logic      [1:0]  acc_src_o,
  output logic      [1:0]  mode_o,
  output logic      [3:0]  cond_sel_o,
  output logic             cond_true_o,
  output logic      [2:0]  flag_num_o,
  output logic      [4:0]  ucyc_o,
  output logic      [2:0]  reads_o,
  output logic             writes_o,
  // Execution status
  output logic             busy_o,
  output logic             done_o,
  output logic             halted_o,
  output logic             ucycle_tick_o,
  // Flag outputs
  output logic      [3:0]  user_flag_o,
  output logic             sel_flag_o,
  output logic             interrupt_enable_flag_o,
  output logic      [7:0]  flag_pulse_o
);

  typedef struct packed {
    bcd_state_e  st;
    logic [2:0]  sy_start;
    logic [2:0]  sy_ujc;
    logic        start_q;
    logic        ujc_q;
    bcd_dec_s    dec;
    logic        cond_true;
    logic [7:0]  flag;
    logic [7:0]  pulse;
    logic [3:0]  user_out;
    logic        sel_out;
    logic        interrupt_enable_flag_out;
    logic [7:0]  opcode;
    logic [7:0]  cnt;
    logic [7:0]  div;
    logic [4:0]  ucnt;
    logic        extended;
    logic        ready;
    logic        busy;
    logic        done;
    logic        halted;
    logic        tick;
    logic        en;
    logic        ack;
    logic [31:0] rdata;
    logic [31:0] icount;
  } bcd_top_s;

  // ----------------------------------------
  // Condition multiplexer
  // ----------------------------------------
  function automatic logic cond_mux(input logic [3:0] cc, input logic [7:0] a, input logic sel,
                                    input logic interrupt_enable_flag, input logic start, input logic ujc);
    case (cc)
      4'h0:   cond_mux = intr_i;
      4'h1:   cond_mux = (a != 8'h00);
      4'h2:   cond_mux = (a == 8'h00);
      4'h3:   cond_mux = a[7];
      4'h4:   cond_mux = a[1];
      4'h5:   cond_mux = sel ? ovf_i : carry_i; // RULE_23
      4'h6:   cond_mux = stk_full_i;
      4'h7:   cond_mux = start;
      4'h8:   cond_mux = a[0];
      4'h9:   cond_mux = interrupt_enable_flag;
      4'ha:   cond_mux = a[2];
      4'hb:   cond_mux = a[3];
      4'hc:   cond_mux = a[4];
      4'hd:   cond_mux = a[5];
      4'he:   cond_mux = a[6];
      default: cond_mux = ujc; // RULE_02
    endcase
  endfunction : cond_mux

  bcd_dec_if dif ();
  bcd_op_decoder u_dec (
    .d (dif.dec_mp)
  );

  bcd_top_s q;
  bcd_top_s n;
  logic     accept;
  logic     cond_val;
  logic     wb_req;

  assign dif.opcode = instr_byte_i;
  assign accept     = instr_valid_i && q.ready;
  assign wb_req     = wb_cyc_i && wb_stb_i && !q.ack;
  assign cond_val   = cond_mux(dif.dec.cond, ac0_i, q.flag[`BCD_FLAG_SEL], q.flag[`BCD_FLAG_INTERRUPT_ENABLE_FLAG],
                               q.start_q, q.ujc_q);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = q;
    n.sy_start = {q.sy_start[1:0], start_sw_i};
    n.sy_ujc   = {q.sy_ujc[1:0], user_jump_condition_in_i};
    if (q.sy_start[1] == q.sy_start[2]) n.start_q = q.sy_start[2];
    if (q.sy_ujc[1] == q.sy_ujc[2]) n.ujc_q = q.sy_ujc[2];
    n.pulse = 8'h00;
    n.done  = 1'b0;
    n.tick  = 1'b0;
    n.ack   = wb_req;
    if (flag_load_i) n.flag = flag_load_data_i;
    if (accept) begin
      n.opcode    = instr_byte_i;
      n.dec       = dif.dec;
      n.cond_true = cond_val;
      n.extended  = 1'b0;
      n.busy      = 1'b1;
      n.cnt       = 8'(MEM_CLKS * (int'(dif.dec.reads) + int'(dif.dec.writes))); // RULE_21
      n.st        = ST_MEM;
      if (dif.dec.op == OP_BRANCH_ON_CONDITION && cond_val) n.dec.ucyc = `BCD_N_BOC_TAKEN; // RULE_14
      case (dif.dec.op)
        OP_SET_FLAG:         n.flag[dif.dec.flag] = 1'b1; // RULE_03
        OP_PULSE_FLAG:       n.pulse[dif.dec.flag] = 1'b1; // RULE_04
        OP_INTERRUPT_RETURN: n.flag[`BCD_FLAG_INTERRUPT_ENABLE_FLAG] = 1'b1;
        default: ;
      endcase
    end
    case (q.st)
      ST_IDLE: ;
      ST_MEM: begin
        if (q.cnt <= 8'd1) begin
          n.st   = ST_UCYC;
          n.div  = 8'h00;
          n.ucnt = q.dec.ucyc;
        end else begin
          n.cnt = q.cnt - 8'd1;
        end
      end
      ST_UCYC: begin
        if (q.div == 8'(UC_CLKS - 1)) begin // RULE_20
          n.div  = 8'h00;
          n.tick = 1'b1;
          if (q.ucnt <= 5'd1) begin
            if (q.dec.skippable && skip_cond_i && !q.extended) begin // RULE_17 RULE_18 RULE_15
              n.ucnt     = `BCD_N_SKIP_ADD;
              n.extended = 1'b1;
            end else if (q.dec.op == OP_HALT) begin
              n.st = ST_HALT_PRESS; // RULE_22
            end else begin
              n.st     = ST_IDLE;
              n.done   = 1'b1;
              n.busy   = 1'b0;
              n.icount = q.icount + 32'd1;
            end
          end else begin
            n.ucnt = q.ucnt - 5'd1;
          end
        end else begin
          n.div = q.div + 8'd1;
        end
      end
      ST_HALT_PRESS: if (q.start_q) n.st = ST_HALT_REL; // RULE_22
      ST_HALT_REL: begin
        if (!q.start_q) begin
          n.st     = ST_IDLE;
          n.done   = 1'b1;
          n.busy   = 1'b0;
          n.icount = q.icount + 32'd1;
        end
      end
      default: n.st = ST_IDLE;
    endcase
    // Register access
    if (wb_cyc_i && wb_stb_i && q.ack && wb_we_i && wb_adr_i == `BCD_REG_CTRL && wb_sel_i[0]) begin
      n.en = wb_dat_i[`BCD_CTRL_EN_BIT];
    end
    if (wb_req) begin
      case (wb_adr_i)
        `BCD_REG_CTRL:   n.rdata = {31'h0, q.en};
        `BCD_REG_STATUS: n.rdata = {10'h0, q.dec.op, q.flag, 5'h0, q.halted, q.busy, q.ready};
        `BCD_REG_LAST:   n.rdata = {7'h0, q.cond_true, 3'h0, q.dec.writes, 1'b0, q.dec.reads,
                                    3'h0, q.dec.ucyc, q.opcode};
        `BCD_REG_COUNT:  n.rdata = q.icount;
        default:         n.rdata = 32'h0;
      endcase
    end
    n.ready    = (n.st == ST_IDLE) && n.en;
    n.halted   = (n.st == ST_HALT_PRESS) || (n.st == ST_HALT_REL);
    n.user_out = n.flag[4:1] | n.pulse[4:1]; // RULE_05
    n.sel_out  = n.flag[`BCD_FLAG_SEL] | n.pulse[`BCD_FLAG_SEL]; // RULE_06
    n.interrupt_enable_flag_out = n.flag[`BCD_FLAG_INTERRUPT_ENABLE_FLAG] | n.pulse[`BCD_FLAG_INTERRUPT_ENABLE_FLAG]; // RULE_06
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q       <= '0;
      q.st    <= ST_IDLE;
      q.dec.op <= OP_NOP;
      q.en    <= `BCD_CTRL_RST;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign wb_dat_o                = q.rdata;
  assign wb_ack_o                = q.ack;
  assign instr_ready_o           = q.ready;
  assign op_class_o              = q.dec.op;
  assign acc_dst_o               = q.dec.acc_dst;
  assign acc_src_o               = q.dec.acc_src;
  assign mode_o                  = q.dec.mode;
  assign cond_sel_o              = q.dec.cond;
  assign cond_true_o             = q.cond_true;
  assign flag_num_o              = q.dec.flag;
  assign ucyc_o                  = q.dec.ucyc;
  assign reads_o                 = q.dec.reads;
  assign writes_o                = q.dec.writes;
  assign busy_o                  = q.busy;
  assign done_o                  = q.done;
  assign halted_o                = q.halted;
  assign ucycle_tick_o           = q.tick;
  assign user_flag_o             = q.user_out;
  assign sel_flag_o              = q.sel_out;
  assign interrupt_enable_flag_o = q.interrupt_enable_flag_out;
  assign flag_pulse_o            = q.pulse;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [7:0] byte_d1;
  logic       cond_d1;
  logic       ovsel_d1;
  always_ff @(posedge clk_i) begin
    byte_d1  <= instr_byte_i;
    cond_d1  <= cond_val;
    ovsel_d1 <= q.flag[`BCD_FLAG_SEL] ? ovf_i : carry_i;
  end

  localparam int RR_CLKS   = MEM_CLKS + 3 * UC_CLKS + 1;
  localparam int HALT_CLKS = MEM_CLKS + UC_CLKS + 1;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_boc_decode;
    accept && instr_byte_i[7:4] == 4'h1 |=> op_class_o == OP_BRANCH_ON_CONDITION && cond_sel_o == byte_d1[3:0];
  endproperty
  a_boc_decode: assert property (p_boc_decode) else $error("branch decode wrong"); // RULE_01
  property p_user_cond;
    accept && instr_byte_i == 8'h1f |=> cond_true_o == $past(q.ujc_q);
  endproperty
  a_user_cond: assert property (p_user_cond) else $error("user condition not routed"); // RULE_02
  property p_set_flag;
    accept && instr_byte_i[7:3] == 5'b00101 && !flag_load_i |=> q.flag[byte_d1[2:0]];
  endproperty
  a_set_flag: assert property (p_set_flag) else $error("flag not set"); // RULE_03
  property p_pulse_flag;
    accept && instr_byte_i[7:3] == 5'b00111 |=> flag_pulse_o == (8'h01 << byte_d1[2:0]) ##1 flag_pulse_o == 8'h00;
  endproperty
  a_pulse_flag: assert property (p_pulse_flag) else $error("flag pulse wrong"); // RULE_04
  property p_user_flag;
    accept && instr_byte_i == 8'h29 && !flag_load_i |=> user_flag_o[0] [*2];
  endproperty
  a_user_flag: assert property (p_user_flag) else $error("user flag 1 not driven"); // RULE_05
  property p_sel_flag;
    accept && instr_byte_i == 8'h2e && !flag_load_i |=> sel_flag_o;
  endproperty
  a_sel_flag: assert property (p_sel_flag) else $error("select flag not driven"); // RULE_06
  property p_reg_reg;
    accept && instr_byte_i[7:6] == 2'b01 |=> acc_src_o == byte_d1[3:2] && acc_dst_o == byte_d1[1:0];
  endproperty
  a_reg_reg: assert property (p_reg_reg) else $error("register fields wrong"); // RULE_07
  property p_store_idx;
    accept && instr_byte_i[7:4] == 4'h9 && instr_byte_i[1] |=> ucyc_o == 5'd12 && writes_o && reads_o == 3'd3;
  endproperty
  a_store_idx: assert property (p_store_idx) else $error("store cost wrong"); // RULE_16 RULE_08
  property p_boc_cost;
    accept && instr_byte_i[7:4] == 4'h1 |=> ucyc_o == (cond_d1 ? 5'd6 : 5'd7);
  endproperty
  a_boc_cost: assert property (p_boc_cost) else $error("branch cost wrong"); // RULE_14
  property p_rr_time;
    accept && instr_byte_i == 8'h40 |-> ##RR_CLKS done_o;
  endproperty
  a_rr_time: assert property (p_rr_time) else $error("short op timing wrong"); // RULE_13 RULE_20 RULE_21
  property p_halt;
    accept && instr_byte_i == 8'h00 |-> ##HALT_CLKS halted_o && !instr_ready_o;
  endproperty
  a_halt: assert property (p_halt) else $error("halt not entered"); // RULE_22
  property p_carry_or_overflow_cond;
    accept && instr_byte_i == 8'h15 |=> cond_true_o == ovsel_d1;
  endproperty
  a_carry_or_overflow_cond: assert property (p_carry_or_overflow_cond) else $error("carry or overflow wrong"); // RULE_23
  property p_nop;
    accept && instr_byte_i == 8'h03 |=> op_class_o == OP_NOP && ucyc_o == 5'd3;
  endproperty
  a_nop: assert property (p_nop) else $error("unassigned opcode not harmless"); // RULE_24

  c_boc_taken: cover property (accept && instr_byte_i[7:4] == 4'h1 && cond_val);
  c_skip_ext:  cover property (q.extended && done_o);
  c_halt_rel:  cover property (q.st == ST_HALT_REL ##1 q.st == ST_IDLE);
  c_store:     cover property (accept && instr_byte_i[7:4] == 4'h9);

endmodule : bcd_top
`default_nettype wire

// ---- verification/bcd_seq_model.sv ----
// Sequencer-side model that offers instruction bytes to the decoder
`timescale 1ns/10ps
`default_nettype none
module bcd_seq_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Bench request
  input  wire logic       go_i,
  input  wire logic [7:0] byte_i,
  // Decoder handshake
  input  wire logic       ready_i,
  output logic            valid_o,
  output logic      [7:0] byte_o,
  output logic            taken_o
);
  always_ff @(posedge clk_i) begin
    taken_o <= !rst_i && !go_i && valid_o && ready_i;
    if (rst_i) begin
      valid_o <= 1'b0;
      byte_o  <= 8'h00;
    end else if (go_i) begin
      valid_o <= 1'b1;
      byte_o  <= byte_i;
    end else if (valid_o && ready_i) begin
      valid_o <= 1'b0;
      byte_o  <= ~byte_o;
    end
  end
endmodule : bcd_seq_model
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench of the opcode decoder and execution timer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import bcd_pkg::*;
  localparam int UC = 4;
  localparam int MC = 2;
  typedef struct packed {logic [7:0] b; logic u; bcd_op_e op; logic [4:0] n; logic [2:0] r; logic w;} bcd_row_s;
  localparam bcd_row_s ROWS [40] = '{
    '{8'h40,0,OP_REG_REG_ADD,3,1,0}, '{8'h5b,0,OP_REG_REG_XOR,3,1,0}, '{8'h66,0,OP_REG_REG_EXCHANGE,5,1,0},
    '{8'h7f,0,OP_REG_REG_AND,3,1,0}, '{8'h80,0,OP_LOAD,8,3,0}, '{8'h93,0,OP_STORE,12,3,1},
    '{8'ha2,0,OP_ADD,10,3,0}, '{8'hb1,0,OP_SKIP_IF_NOT_EQUAL,9,3,0}, '{8'hc0,0,OP_AND,8,3,0},
    '{8'hd1,0,OP_OR,8,3,0}, '{8'he2,0,OP_SKIP_IF_AND_ZERO,11,3,0}, '{8'hf3,0,OP_SUBTRACT,10,3,0},
    '{8'hc4,0,OP_JUMP,11,2,0}, '{8'hd5,0,OP_JUMP_TO_SUBROUTINE,14,2,0}, '{8'he6,0,OP_INCREMENT_SKIP_ZERO,13,3,1},
    '{8'hf4,0,OP_DECREMENT_SKIP_ZERO,11,3,1}, '{8'h20,0,OP_LOAD_IMMEDIATE,5,2,0},
    '{8'h30,0,OP_ADD_IMMEDIATE_SKIP_ZERO,6,2,0}, '{8'hc8,0,OP_EXCHANGE_WITH_STACK,5,1,0},
    '{8'hcd,0,OP_PUSH,3,1,0}, '{8'hda,0,OP_PULL,3,1,0}, '{8'hdc,0,OP_NEGATE_ACCUMULATOR,3,1,0},
    '{8'he8,0,OP_SHIFT_LEFT,3,1,0}, '{8'hec,0,OP_SHIFT_RIGHT,3,1,0}, '{8'hf8,0,OP_ROTATE_LEFT,3,1,0},
    '{8'hfc,0,OP_ROTATE_RIGHT,3,1,0}, '{8'h0e,0,OP_PULL_STATUS,4,1,0}, '{8'h07,0,OP_PUSH_STATUS,4,1,0},
    '{8'h01,0,OP_INTERRUPT_RETURN,5,1,0}, '{8'h02,0,OP_SUB_RETURN,4,1,0}, '{8'h04,0,OP_NOP,3,1,0},
    '{8'h03,0,OP_NOP,3,1,0}, '{8'h1f,1,OP_BRANCH_ON_CONDITION,6,2,0},
    '{8'h1f,0,OP_BRANCH_ON_CONDITION,7,2,0}, '{8'h15,1,OP_BRANCH_ON_CONDITION,6,2,0},
    '{8'h2a,0,OP_SET_FLAG,3,1,0}, '{8'h29,0,OP_SET_FLAG,3,1,0},
    '{8'h2e,0,OP_SET_FLAG,3,1,0}, '{8'h2f,0,OP_SET_FLAG,3,1,0},
    '{8'h3b,0,OP_PULSE_FLAG,3,1,0}};
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, go = 0, ujc = 0, ssw = 0, skc = 0, cy = 1;
  logic [3:0] sel = 0;
  logic [7:0] adr = 0, gob = 0, ac0 = 8'h01;
  logic [31:0] wdat = 0, rd, wb_dat;
  logic ack, ready, valid, taken, ct, wr, done, halted, self, interrupt_enable_flag;
  logic [7:0] ibyte;
  logic [4:0] ucyc;
  logic [1:0] mode;
  logic [2:0] fnum;
  logic busy, tick;
  logic [2:0] reads;
  logic [3:0] uflag;
  bcd_op_e op_class;
  int n_mismatch = 0, checks_done = 0, cnt, nt;

  always #12.5 clk_i = ~clk_i;

  bcd_seq_model seq (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .byte_i(gob), .ready_i(ready),
    .valid_o(valid), .byte_o(ibyte), .taken_o(taken));

  bcd_top #(.UC_CLKS(UC), .MEM_CLKS(MC)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat), .wb_ack_o(ack),
    .instr_valid_i(valid), .instr_byte_i(ibyte), .instr_ready_o(ready), .ac0_i(ac0), .carry_i(cy),
    .ovf_i(1'b0), .stk_full_i(1'b0), .intr_i(1'b0), .skip_cond_i(skc), .flag_load_i(1'b0),
    .flag_load_data_i(8'h00), .user_jump_condition_in_i(ujc), .start_sw_i(ssw), .op_class_o(op_class),
    .acc_dst_o(), .acc_src_o(), .mode_o(mode), .cond_sel_o(), .cond_true_o(ct), .flag_num_o(fnum), .ucyc_o(ucyc),
    .reads_o(reads), .writes_o(wr), .busy_o(busy), .done_o(done), .halted_o(halted), .ucycle_tick_o(tick),
    .user_flag_o(uflag), .sel_flag_o(self), .interrupt_enable_flag_o(interrupt_enable_flag), .flag_pulse_o());

  task automatic finish_test;
    if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  task automatic chk(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("Error at %0t: %s mismatch", $time, what);
    end
  endtask : chk

  // Bounded wait: 0 byte taken, 1 done, 2 halted
  task automatic wt(input int k);
    for (int j = 0; j < 600; j++) begin
      @(posedge clk_i);
      #1;
      cnt++;
      nt += tick;
      if ((k == 0 && taken) || (k == 1 && done) || (k == 2 && halted)) return;
    end
    n_mismatch++;
    finish_test;
  endtask : wt

  task automatic offer(input logic [7:0] b);
    @(posedge clk_i);
    go  <= 1'b1;
    gob <= b;
    @(posedge clk_i);
    go  <= 1'b0;
    wt(0);
    cnt = 0;
    nt = 0;
  endtask : offer

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hf;
    wdat <= d;
    for (int j = 0; j < 20; j++) begin
      @(posedge clk_i);
      if (ack === 1'b1) begin
        rd = wb_dat;
        cyc <= 1'b0;
        stb <= 1'b0;
        return;
      end
    end
    n_mismatch++;
    finish_test;
  endtask : wb

  initial begin
    #2000000;
    n_mismatch++;
    finish_test;
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ROWS[i]) begin
      @(posedge clk_i);
      ujc <= ROWS[i].u;
      repeat (6) @(posedge clk_i);
      offer(ROWS[i].b);
      wt(1);
      chk(cnt == MC * (ROWS[i].r + ROWS[i].w) + UC * ROWS[i].n && nt == ROWS[i].n, "duration");
      chk(busy === 1'b0 && (!ROWS[i].b[7] || mode === ROWS[i].b[1:0]), "mode");
      if (ROWS[i].b[7:5] == 3'b001 && ROWS[i].b[3]) chk(fnum === ROWS[i].b[2:0], "flag number");
      chk(op_class === ROWS[i].op, "class");
      chk(ucyc === ROWS[i].n && reads === ROWS[i].r && wr === ROWS[i].w, "cost");
      if (ROWS[i].b[7:4] == 4'h1) chk(ct === ROWS[i].u, "condition");
    end
    chk(uflag === 4'h3 && self === 1'b1 && interrupt_enable_flag === 1'b1, "flags");
    @(posedge clk_i);
    skc <= 1'b1;
    offer(8'hb1);
    wt(1);
    chk(cnt == MC * 3 + UC * 12, "skip");
    skc <= 1'b0;
    offer(8'h00);
    wt(2);
    @(posedge clk_i);
    ssw <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk(halted === 1'b1 && done === 1'b0, "halt");
    ssw <= 1'b0;
    wt(1);
    wb(1'b0, 8'h00, 32'h0);
    chk(rd === 32'h1, "ctrl reset");
    wb(1'b1, 8'h00, 32'h0);
    repeat (3) @(posedge clk_i);
    chk(ready === 1'b0, "disable");
    wb(1'b0, 8'h40, 32'h0);
    chk(rd === 32'h0, "unmapped");
    wb(1'b1, 8'h00, 32'h1);
    finish_test;
  end
endmodule : tb_top
`default_nettype wire
